// ---- codec_model.sv ----
// Behavioural stereo codec facing the serial audio port
`timescale 1ns/100ps
module codec_model (
  input wire logic ref_clk_i,
  input wire logic en_i,
  input wire logic sclk_i,
  input wire logic lrck_i,
  input wire logic [3:0] line_i,
  input wire logic [23:0] word_i [8],
  output logic [2:0] line_o,
  output logic [23:0] got_o [8],
  output logic [5:0] len_l_o,
  output logic [5:0] len_r_o,
  output logic [7:0] viol_o
);
  logic sclk_q, lrck_q, lrck_f;
  logic [5:0] cnt, rc;
  logic [23:0] sr [4];
  int i, ofs;

  initial begin
    {sclk_q, lrck_q, lrck_f, line_o, cnt, rc, len_l_o, len_r_o, viol_o} = '0;
    for (i = 0; i < 8; i++) begin
      got_o[i] = 24'h0;
      sr[i % 4] = 24'h0;
    end
  end

  // Pins oversampled on the system clock
  always @(posedge ref_clk_i) begin
    sclk_q <= sclk_i;
    lrck_q <= lrck_i;
    if (en_i && lrck_i !== lrck_q && !(sclk_q && !sclk_i)) begin
      viol_o <= viol_o + 8'h1;
    end
    if (sclk_q && !sclk_i) begin
      ofs = lrck_f ? 4 : 0;
      if (lrck_i !== lrck_f) begin
        lrck_f <= lrck_i;
        for (i = 0; i < 4; i++) begin
          got_o[i + ofs] <= sr[i];
          sr[i] <= 24'h0;
        end
        if (lrck_f) begin
          len_r_o <= cnt;
        end else begin
          len_l_o <= cnt;
        end
        cnt <= 6'h1;
        rc <= 6'h0;
        line_o <= 3'h0;
      end else begin
        // MSB launched one clock after the frame edge
        cnt <= cnt + 6'h1;
        for (i = 0; i < 3; i++) begin
          line_o[i] <= (cnt > 6'h0 && cnt <= 6'h18) ? word_i[i + ofs][24 - int'(cnt)] : 1'b0;
        end
      end
    end
    if (!sclk_q && sclk_i) begin
      rc <= rc + 6'h1;
      for (i = 0; i < 4; i++) begin
        if (rc > 6'h0 && rc <= 6'h18) begin
          sr[i][24 - int'(rc)] <= line_i[i];
        end
      end
    end
  end
endmodule

// ---- codec_port_i2s.sv ----
// Stereo serial audio port master with per-line shift registers
`timescale 1ns/100ps
module codec_port_i2s
  import codec_port_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic enable_i,
  input wire logic [2:0] mode_i,
  input wire logic [1:0] width_i,
  input wire logic short_frame_i,
  input wire logic [7:0] sclk_div_i,
  input wire logic mclk_en_i,
  // Transmit samples, one word per line and channel, ordered by DMA slot
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [SAMPLE_W-1:0] tx_data_i,
  input wire logic [3:0] tx_dma_slot_i,
  // Receive samples
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [SAMPLE_W-1:0] rx_data_o,
  output logic [3:0] rx_dma_slot_o,
  output logic rx_overrun_o,
  output logic tx_underrun_o,
  // Pins
  output logic port_frame_pin_o,
  output logic port_frame_pin_oe_o,
  input wire logic port_frame_pin_i,
  output logic port_clock_pin_o,
  output logic port_clock_pin_oe_o,
  input wire logic port_clock_pin_i,
  output logic port_data_out_pin_o,
  output logic port_data_in_pin_o,
  output logic port_data_in_pin_oe_o,
  input wire logic port_data_in_pin_i,
  output logic codec_reset_pin_o,
  output logic codec_reset_pin_oe_o,
  input wire logic codec_reset_pin_i,
  output logic port_extra_pin_o,
  output logic port_extra_pin_oe_o,
  input wire logic port_extra_pin_i,
  // General-purpose mode data
  input wire logic gp_data_out_i,
  output logic gp_data_in_o,
  input wire logic gp_frame_oe_i,
  input wire logic gp_frame_i,
  input wire logic gp_clock_oe_i,
  input wire logic gp_clock_i,
  output logic gp_frame_o,
  output logic gp_clock_o,
  input wire logic codec_reset_i
);

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  logic [NUM_OUT-1:0] out_act;
  logic [NUM_IN-1:0] in_act;
  logic i2s_mode;

  always_comb begin
    out_act = '0;
    in_act = '0;
    i2s_mode = 1'b1;
    case (mode_i)
      MODE_OUT3_IN1: begin
        out_act = 4'b0111;
        in_act = 3'b001;
      end
      MODE_OUT2_IN2: begin
        out_act = 4'b0011;
        in_act = 3'b011;
      end
      MODE_OUT1_IN3: begin
        out_act = 4'b0001;
        in_act = 3'b111;
      end
      MODE_OUT4_IN0: begin
        out_act = 4'b1111;
      end
      default: begin
        i2s_mode = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Serial clock divider: one enable per half period
  // ------------------------------------------------------------
  logic [7:0] div_r;
  logic half_tick;
  logic sclk_r;
  logic run;

  assign run = enable_i & i2s_mode & mclk_en_i;
  assign half_tick = run & (div_r == '0);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      div_r <= '0;
    end else if (!run || div_r == '0) begin
      div_r <= (sclk_div_i == '0) ? '0 : sclk_div_i - 8'h01;
    end else begin
      div_r <= div_r - 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !run) begin
      sclk_r <= 1'b0;
    end else if (half_tick) begin
      sclk_r <= ~sclk_r;
    end
  end

  logic fall_tick;
  logic rise_tick;
  assign fall_tick = half_tick & sclk_r;
  assign rise_tick = half_tick & ~sclk_r;

  // ------------------------------------------------------------
  // Frame sequencer
  // ------------------------------------------------------------
  frame_state_t state_r;
  logic [5:0] bit_r;
  logic lrck_r;
  logic [5:0] slot_len;
  logic [4:0] wbits;

  assign slot_len = short_frame_i ? SLOT_CLKS_SHORT : SLOT_CLKS_STD;
  always_comb begin
    case (width_i)
      WIDTH_16: wbits = 5'd16;
      WIDTH_18: wbits = 5'd18;
      WIDTH_20: wbits = 5'd20;
      default: wbits = 5'd24;
    endcase
    if (short_frame_i && wbits > 5'd15) begin
      wbits = 5'd15;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !run) begin
      state_r <= ST_IDLE;
      bit_r <= '0;
      lrck_r <= 1'b0;
    end else if (fall_tick) begin
      case (state_r)
        ST_IDLE: begin
          state_r <= ST_LEFT;
          bit_r <= '0;
          lrck_r <= 1'b0;
        end
        ST_LEFT: begin
          if (bit_r == slot_len - 6'h01) begin
            state_r <= ST_RIGHT;
            bit_r <= '0;
            lrck_r <= 1'b1;
          end else begin
            bit_r <= bit_r + 6'h01;
          end
        end
        ST_RIGHT: begin
          if (bit_r == slot_len - 6'h01) begin
            state_r <= ST_LEFT;
            bit_r <= '0;
            lrck_r <= 1'b0;
          end else begin
            bit_r <= bit_r + 6'h01;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  logic slot_end;
  logic right_now;
  assign slot_end = fall_tick & (state_r != ST_IDLE) & (bit_r == slot_len - 6'h01);
  assign right_now = (state_r == ST_LEFT); // Slot about to begin at slot_end

  // ------------------------------------------------------------
  // Transmit path: FIFO then per-line holding words
  // ------------------------------------------------------------
  logic fifo_valid;
  logic fifo_ready;
  logic [SAMPLE_W+3:0] fifo_data;
  logic [SAMPLE_W-1:0] hold_r [NUM_OUT*2];
  logic [SAMPLE_W-1:0] tx_sh_r [NUM_OUT];
  logic [3:0] fslot;
  logic [NUM_OUT-1:0] txd;

  sample_fifo #(
    .WIDTH(SAMPLE_W + 4),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i({tx_dma_slot_i, tx_data_i}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready),
    .out_data_o(fifo_data)
  );

  // Holding buffer filled between frames; stalls FIFO once loaded
  logic [NUM_OUT*2-1:0] hold_full_r;
  logic [2:0] hidx;
  assign fslot = fifo_data[SAMPLE_W+3:SAMPLE_W];
  assign hidx = {fslot[2], fslot[1:0]};
  assign fifo_ready = fifo_valid & ~hold_full_r[hidx];

  always_ff @(posedge ref_clk_i) begin
    if (fifo_ready) begin
      hold_r[hidx] <= fifo_data[SAMPLE_W-1:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_tx
      logic [SAMPLE_W-1:0] next_word;
      logic [SAMPLE_W-1:0] mask;
      assign mask = {SAMPLE_W{1'b1}} << (SAMPLE_W - int'(wbits));
      // Empty holding word goes out as zeros
      assign next_word = (right_now ? (hold_full_r[g + RIGHT_SLOT_OFS] ? hold_r[g + RIGHT_SLOT_OFS] : '0)
        : (hold_full_r[g] ? hold_r[g] : '0)) & mask;
      // Line stays low for the clock right after the frame edge
      assign txd[g] = tx_sh_r[g][SAMPLE_W-1] & (bit_r != 6'h00);
      always_ff @(posedge ref_clk_i) begin
        if (rst_i || !run || !out_act[g]) begin
          tx_sh_r[g] <= '0;
        end else if (slot_end) begin
          tx_sh_r[g] <= next_word;
        end else if (fall_tick && state_r != ST_IDLE && bit_r != 6'h00) begin
          tx_sh_r[g] <= {tx_sh_r[g][SAMPLE_W-2:0], 1'b0};
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hold_full_r <= '0;
      tx_underrun_o <= 1'b0;
    end else begin
      for (int k = 0; k < NUM_OUT*2; k++) begin
        if (fifo_ready && hidx == 3'(k)) begin
          hold_full_r[k] <= 1'b1;
        end else if (slot_end && ((right_now && k >= RIGHT_SLOT_OFS) || (!right_now && k < RIGHT_SLOT_OFS))) begin
          hold_full_r[k] <= 1'b0;
        end
      end
      tx_underrun_o <= slot_end & |(out_act & ~(right_now ? hold_full_r[7:4] : hold_full_r[3:0]));
    end
  end

  // ------------------------------------------------------------
  // Receive path: per-line shift registers, sampled on rising edges
  // ------------------------------------------------------------
  logic [NUM_IN-1:0] sdin;
  logic [SAMPLE_W-1:0] rx_sh_r [NUM_IN];
  logic [SAMPLE_W-1:0] rx_cap_r [NUM_IN];
  logic [NUM_IN-1:0] rx_pend_r;
  logic rx_right_r;

  always_comb begin
    sdin = '0;
    case (mode_i)
      MODE_OUT3_IN1: sdin = {2'b00, port_extra_pin_i};
      MODE_OUT2_IN2: sdin = {1'b0, port_extra_pin_i, codec_reset_pin_i};
      MODE_OUT1_IN3: sdin = {port_extra_pin_i, codec_reset_pin_i, port_data_in_pin_i};
      default: sdin = '0;
    endcase
  end

  generate
    for (g = 0; g < NUM_IN; g++) begin : g_rx
      always_ff @(posedge ref_clk_i) begin
        if (rst_i || !run) begin
          rx_sh_r[g] <= '0;
        end else if (rise_tick && in_act[g] && state_r != ST_IDLE && bit_r != 6'h00 && bit_r <= 6'(wbits)) begin
          rx_sh_r[g] <= rx_sh_r[g] | (SAMPLE_W'(sdin[g]) << (SAMPLE_W - int'(bit_r)));
        end else if (slot_end) begin
          rx_sh_r[g] <= '0;
        end
      end
      always_ff @(posedge ref_clk_i) begin
        if (slot_end) begin
          rx_cap_r[g] <= rx_sh_r[g];
        end
      end
    end
  endgenerate

  // Capture words drained in line order; overrun if a frame half is lost
  logic [1:0] rx_sel;
  always_comb begin
    rx_sel = 2'd0;
    if (rx_pend_r[0]) begin
      rx_sel = 2'd0;
    end else if (rx_pend_r[1]) begin
      rx_sel = 2'd1;
    end else begin
      rx_sel = 2'd2;
    end
  end

  assign rx_valid_o = |rx_pend_r;
  assign rx_data_o = rx_cap_r[rx_sel];
  assign rx_dma_slot_o = {1'b0, rx_right_r, rx_sel};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_pend_r <= '0;
      rx_right_r <= 1'b0;
      rx_overrun_o <= 1'b0;
    end else begin
      rx_overrun_o <= 1'b0;
      if (slot_end && run) begin
        rx_pend_r <= in_act;
        rx_right_r <= (state_r == ST_RIGHT);
        rx_overrun_o <= |rx_pend_r;
      end else if (rx_valid_o && rx_ready_i) begin
        rx_pend_r[rx_sel] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin multiplexing; no command words on the link
  // ------------------------------------------------------------
  always_comb begin
    port_frame_pin_o = lrck_r;
    port_frame_pin_oe_o = 1'b1;
    port_clock_pin_o = sclk_r;
    port_clock_pin_oe_o = 1'b1;
    port_data_out_pin_o = txd[0];
    port_data_in_pin_o = 1'b0;
    port_data_in_pin_oe_o = 1'b0;
    codec_reset_pin_o = 1'b0;
    codec_reset_pin_oe_o = 1'b0;
    port_extra_pin_o = 1'b0;
    port_extra_pin_oe_o = 1'b0;
    case (mode_i)
      MODE_OUT3_IN1: begin
        port_data_in_pin_o = txd[1];
        port_data_in_pin_oe_o = 1'b1;
        codec_reset_pin_o = txd[2];
        codec_reset_pin_oe_o = 1'b1;
      end
      MODE_OUT2_IN2: begin
        port_data_in_pin_o = txd[1];
        port_data_in_pin_oe_o = 1'b1;
      end
      MODE_OUT4_IN0: begin
        port_data_in_pin_o = txd[1];
        port_data_in_pin_oe_o = 1'b1;
        codec_reset_pin_o = txd[2];
        codec_reset_pin_oe_o = 1'b1;
        port_extra_pin_o = txd[3];
        port_extra_pin_oe_o = 1'b1;
      end
      MODE_OUT1_IN3: begin
      end
      default: begin
        port_frame_pin_o = gp_frame_i;
        port_frame_pin_oe_o = gp_frame_oe_i;
        port_clock_pin_o = gp_clock_i;
        port_clock_pin_oe_o = gp_clock_oe_i;
        port_data_out_pin_o = gp_data_out_i;
        codec_reset_pin_o = codec_reset_i;
        codec_reset_pin_oe_o = 1'b1;
      end
    endcase
  end

  assign gp_data_in_o = port_data_in_pin_i;
  assign gp_frame_o = port_frame_pin_i;
  assign gp_clock_o = port_clock_pin_i;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_lrck_on_fall: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $changed(lrck_r) && run |-> $past(fall_tick)) else $error("LRCK moved off a falling edge");
  a_lrck_idle_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !run |=> !lrck_r && tx_sh_r[0] == '0) else $error("LRCK or data high while idle");
  a_msb_delay: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_r != ST_IDLE && bit_r == 6'h00 |-> !port_data_out_pin_o) else $error("Data bit on frame edge clock");
  a_slot_len_std: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !short_frame_i |-> bit_r < 6'd32) else $error("Slot longer than 32 clocks");
  a_right_high: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_r == ST_RIGHT |-> lrck_r) else $error("LRCK low in right slot");
  a_left_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_r == ST_LEFT |-> !lrck_r) else $error("LRCK high in left slot");
  a_msb_load: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    slot_end && out_act[0] |=> tx_sh_r[0] == $past(g_tx[0].next_word)) else $error("MSB not loaded at slot");
  a_pad_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    width_i == WIDTH_16 && !short_frame_i |-> tx_sh_r[0][7:0] == 8'h00) else $error("Pad bits not zero");
  a_mode7_noin: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    mode_i == MODE_OUT4_IN0 |-> port_extra_pin_oe_o && in_act == '0) else $error("Mode 7 pin roles wrong");
  a_rx_slot_map: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rx_valid_o |-> rx_dma_slot_o != 4'd3 && rx_dma_slot_o < 4'd7) else $error("Bad receive DMA slot");
endmodule

// ---- codec_port_i2s_modes_bench.sv ----
// Self-checking bench for the stereo serial audio port
`timescale 1ns/100ps
module codec_port_i2s_modes_bench;
  import codec_port_pkg::*;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, enable_i = 1'b0, short_frame_i = 1'b0, mclk_en_i = 1'b1;
  logic [2:0] mode_i = 3'h4;
  logic [1:0] width_i = 2'h3;
  logic [7:0] sclk_div_i = 8'h04;
  logic tx_valid_i = 1'b0, rx_ready_i = 1'b0, gp_data_out_i = 1'b0, gp_frame_oe_i = 1'b0;
  logic gp_frame_i = 1'b0, gp_clock_oe_i = 1'b0, gp_clock_i = 1'b0, codec_reset_i = 1'b0;
  logic ext_d = 1'b1, feed = 1'b0, saw_full = 1'b0;
  logic [23:0] tx_data_i = 24'h0;
  logic [3:0] tx_dma_slot_i = 4'h0, run_id = 4'h0;
  logic tx_ready_o, rx_valid_o, rx_overrun_o, tx_underrun_o, gp_data_in_o, gp_frame_o, gp_clock_o;
  logic [23:0] rx_data_o;
  logic [3:0] rx_dma_slot_o;
  logic port_frame_pin_o, port_frame_pin_oe_o, port_clock_pin_o, port_clock_pin_oe_o;
  logic port_data_out_pin_o, port_data_in_pin_o, port_data_in_pin_oe_o;
  logic codec_reset_pin_o, codec_reset_pin_oe_o, port_extra_pin_o, port_extra_pin_oe_o;
  logic [2:0] cin;
  logic [23:0] c_tx [8], c_got [8], rx_got [16];
  logic [15:0] rx_seen = 16'h0;
  logic [7:0] omask = 8'h0, viol;
  logic [5:0] len_l, len_r;
  int mismatches = 0, n_checks = 0;
  int n_und = 0, n_ovr = 0;
  wire port_frame_pin_i = port_frame_pin_oe_o ? port_frame_pin_o : ext_d;
  wire port_clock_pin_i = port_clock_pin_oe_o ? port_clock_pin_o : ext_d;
  wire port_data_in_pin_i = port_data_in_pin_oe_o ? port_data_in_pin_o : (mode_i == 3'h6 ? cin[0] : ext_d);
  wire codec_reset_pin_i = codec_reset_pin_oe_o ? codec_reset_pin_o :
    (mode_i == 3'h5 ? cin[0] : (mode_i == 3'h6 ? cin[1] : ext_d));
  wire port_extra_pin_i = port_extra_pin_oe_o ? port_extra_pin_o : (mode_i == 3'h4 ? cin[0] :
    (mode_i == 3'h5 ? cin[1] : (mode_i == 3'h6 ? cin[2] : ext_d)));

  always #2.5 ref_clk_i = ~ref_clk_i;

  codec_port_i2s #(.FIFO_DEPTH(4)) dut_u (.ref_clk_i, .rst_i, .enable_i, .mode_i, .width_i, .short_frame_i,
    .sclk_div_i, .mclk_en_i, .tx_valid_i, .tx_ready_o, .tx_data_i, .tx_dma_slot_i, .rx_valid_o, .rx_ready_i,
    .rx_data_o, .rx_dma_slot_o, .rx_overrun_o, .tx_underrun_o, .port_frame_pin_o, .port_frame_pin_oe_o,
    .port_frame_pin_i, .port_clock_pin_o, .port_clock_pin_oe_o, .port_clock_pin_i, .port_data_out_pin_o,
    .port_data_in_pin_o, .port_data_in_pin_oe_o, .port_data_in_pin_i, .codec_reset_pin_o, .codec_reset_pin_oe_o,
    .codec_reset_pin_i, .port_extra_pin_o, .port_extra_pin_oe_o, .port_extra_pin_i, .gp_data_out_i,
    .gp_data_in_o, .gp_frame_oe_i, .gp_frame_i, .gp_clock_oe_i, .gp_clock_i, .gp_frame_o, .gp_clock_o,
    .codec_reset_i);

  codec_model codec_u (.ref_clk_i(ref_clk_i), .en_i(enable_i), .sclk_i(port_clock_pin_i),
    .lrck_i(port_frame_pin_i), .line_i({port_extra_pin_i, codec_reset_pin_i, port_data_in_pin_i,
    port_data_out_pin_o}), .word_i(c_tx), .line_o(cin), .got_o(c_got), .len_l_o(len_l), .len_r_o(len_r),
    .viol_o(viol));

  function automatic logic [23:0] wrd(input int s);
    return 24'h3c5a97 ^ {3{run_id, 4'(s)}};
  endfunction

  function automatic logic [3:0] nxt(input logic [3:0] c);
    logic [3:0] n;
    n = c;
    for (int k = 0; k < 8; k++) begin
      n = (n + 4'h1) & 4'h7;
      if (omask[n[2:0]]) break;
    end
    return n;
  endfunction

  // ----------------------------------------
  // Transmit feeder and stalling receive sink
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    rx_ready_i <= ~rx_ready_i;
    if (rx_valid_o === 1'b1 && rx_ready_i) begin
      rx_got[rx_dma_slot_o] <= rx_data_o;
      rx_seen[rx_dma_slot_o] <= 1'b1;
    end
    if (tx_valid_i && tx_ready_o === 1'b0) begin
      saw_full <= 1'b1;
    end
    if (tx_underrun_o === 1'b1) begin
      n_und <= n_und + 1;
    end
    if (rx_overrun_o === 1'b1) begin
      n_ovr <= n_ovr + 1;
    end
    if (!feed) begin
      tx_valid_i <= 1'b0;
    end else if (!tx_valid_i || tx_ready_o === 1'b1) begin
      tx_valid_i <= 1'b1;
      tx_dma_slot_i <= nxt(tx_dma_slot_i);
      tx_data_i <= wrd(int'(nxt(tx_dma_slot_i)));
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_frames(input int n, output int cyc);
    int k;
    logic pl;
    k = 0;
    cyc = 0;
    pl = port_frame_pin_o;
    for (int t = 0; t < 20000 && k < n; t++) begin
      @(posedge ref_clk_i);
      cyc++;
      if (port_frame_pin_o && !pl) begin
        k++;
        cyc = (k < n) ? 0 : cyc;
      end
      pl = port_frame_pin_o;
    end
    if (k < n) begin
      mismatches++;
      summarize();
    end
  endtask

  task automatic run(input logic [2:0] m, input logic [1:0] w, input logic s, input int no, input int ni);
    logic [7:0] im;
    logic [23:0] mk;
    int bits, cyc;
    im = 8'((1 << ni) - 1);
    im = im | (im << 4);
    bits = s ? 15 : (w == 2'h0 ? 16 : (w == 2'h1 ? 18 : (w == 2'h2 ? 20 : 24)));
    mk = ~(24'hffffff >> bits);
    run_id = run_id + 4'h1;
    for (int k = 0; k < 8; k++) c_tx[k] = ~wrd(k);
    omask <= 8'((1 << no) - 1) | 8'(((1 << no) - 1) << 4);
    mode_i <= m;
    width_i <= w;
    short_frame_i <= s;
    rx_seen <= 16'h0;
    saw_full <= 1'b0;
    @(posedge ref_clk_i);
    enable_i <= 1'b1;
    feed <= 1'b1;
    wait_frames(3, cyc);
    n_und <= 0;
    n_ovr <= 0;
    wait_frames(3, cyc);
    chk(24'(cyc), s ? 24'h100 : 24'h200);
    for (int k = 0; k < 8; k++) if (omask[k]) chk(c_got[k], wrd(k) & mk);
    for (int k = 0; k < 8; k++) if (im[k]) chk(rx_got[k], ~wrd(k) & mk);
    chk({8'h0, rx_seen}, {16'h0, im});
    chk({len_l, len_r}, s ? 24'h410 : 24'h820);
    chk({viol, saw_full}, 24'h1);
    chk(24'(n_und + n_ovr), 24'h0);
    feed <= 1'b0;
    wait_frames(2, cyc);
    enable_i <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk({20'h0, port_frame_pin_o, port_clock_pin_o, port_data_out_pin_o, tx_ready_o}, 24'h1);
    enable_i <= 1'b1;
    mclk_en_i <= 1'b0;
    repeat (100) @(posedge ref_clk_i);
    chk({23'h0, port_clock_pin_o}, 24'h0);
    enable_i <= 1'b0;
    mclk_en_i <= 1'b1;
    run(3'h4, 2'h3, 1'b0, 3, 1);
    run(3'h5, 2'h0, 1'b0, 2, 2);
    run(3'h6, 2'h1, 1'b0, 1, 3);
    run(3'h7, 2'h2, 1'b0, 4, 0);
    run(3'h7, 2'h0, 1'b1, 4, 0);
    mode_i <= 3'h0;
    for (int v = 0; v < 2; v++) begin
      gp_frame_oe_i <= 1'b1;
      gp_frame_i <= v[0];
      gp_clock_oe_i <= 1'b0;
      ext_d <= ~v[0];
      gp_data_out_i <= v[0];
      codec_reset_i <= ~v[0];
      repeat (3) @(posedge ref_clk_i);
      chk({14'h0, port_frame_pin_oe_o, port_frame_pin_o, port_clock_pin_oe_o, gp_clock_o, port_data_out_pin_o,
        port_data_in_pin_oe_o, gp_data_in_o, codec_reset_pin_oe_o, codec_reset_pin_o, gp_frame_o},
        v[0] ? 24'h325 : 24'h24e);
    end
    summarize();
  end
endmodule

// ---- codec_port_pkg.sv ----
// Constants and types for the serial audio codec port
// Summary of operation
// - All four stereo modes share one serial format; only line counts differ.
// - Mode 4 drives three output lines and takes one input line.
// - Frame pin carries LRCK, clock pin SCLK; modes 4 to 7 set line roles.
// - Full duplex, two slots per frame; slot 0 left, slot 1 right.
// - Each slot is 32 serial clocks, 64 per LRCK period.
// - Serial clock is divided down from the codec master clock.
// - LRCK has 50% duty, low for left slot and high for right.
// - LRCK changes on the falling serial clock edge.
// - Transmit data launched on falling edges, receive sampled on rising edges.
// - Sample MSB appears one serial clock after the LRCK edge.
// - Each output and input line has its own 24-bit shift register.
// - Widths 16, 18, 20 or 24 bits; unused slot bits padded with zeros. With short_frame_i set, every width is cut to 15 bits.
// - No command or status words travel on the serial audio link.
// - A 32-to-1 serial clock to LRCK ratio is also supported.
// - Fourteen DMA slot bits 0 to 13; each line slot maps distinctly.
// - Output line n maps left to DMA slot n-1, right to n+3.
// - Input line n maps left to DMA slot n-1, right to n+3.
// - Mode 0 has two-way frame and clock pins, data out, data in, reset out.
package codec_port_pkg;

  localparam int SAMPLE_W = 24;
  localparam int NUM_OUT = 4;
  localparam int NUM_IN = 3;
  localparam int DMA_SLOTS = 14;
  localparam int RIGHT_SLOT_OFS = 4;
  localparam logic [5:0] SLOT_CLKS_STD = 6'h20;
  localparam logic [5:0] SLOT_CLKS_SHORT = 6'h10;
  localparam logic [7:0] MCLK_DIV_DEFAULT = 8'h02;

  typedef enum logic [2:0] {
    MODE_GP = 3'h0,
    MODE_OUT3_IN1 = 3'h4,
    MODE_OUT2_IN2 = 3'h5,
    MODE_OUT1_IN3 = 3'h6,
    MODE_OUT4_IN0 = 3'h7
  } port_mode_t;

  typedef enum logic [1:0] {
    WIDTH_16 = 2'h0,
    WIDTH_18 = 2'h1,
    WIDTH_20 = 2'h2,
    WIDTH_24 = 2'h3
  } sample_width_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LEFT = 3'b010,
    ST_RIGHT = 3'b100
  } frame_state_t;

endpackage

// ---- sample_fifo.sv ----
// Small synchronous FIFO for sample words
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_r[rd_r];

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
